// *** prg_map.svh ***
// register offsets, field positions, reset values and codes of the pulse reference gear input
// assumes a 32-bit Avalon-MM slave port with byte addresses and a 200 MHz sys_clk
`ifndef PRG_MAP_SVH
`define PRG_MAP_SVH

// ==========================================================
// register offsets
`define PRG_OFF_CTRL 5'h00
`define PRG_OFF_NUM1 5'h04
`define PRG_OFF_DENOM 5'h08
`define PRG_OFF_NUM2 5'h0C
`define PRG_OFF_ERR 5'h10
`define PRG_OFF_REF 5'h14
`define PRG_OFF_STAT 5'h18

// ==========================================================
// control word fields
`define PRG_FORM_LSB 0
`define PRG_INV_LSB 4
`define PRG_CLR_LSB 8
`define PRG_GSW_EN_BIT 12
`define PRG_GSW_SEQ_BIT 13
`define PRG_RESTART_BIT 31

// ==========================================================
// codes and limits
`define PRG_FORM_PD 3'h0
`define PRG_FORM_FR 3'h1
`define PRG_FORM_Q1 3'h2
`define PRG_FORM_Q2 3'h3
`define PRG_FORM_Q4 3'h4
`define PRG_CLR_OFF 2'h0
`define PRG_CLR_NEVER 2'h1
`define PRG_CLR_ALL 2'h2
`define PRG_GEAR_MIN 17'h0_0001
`define PRG_GEAR_MAX 17'h1_86A0
`define PRG_GEAR_RST 17'h0_0001

`endif

// *** prg_pkg.sv ***
// types shared by the pulse reference gear input
// assumes prg_map.svh holds the numbers
package prg_pkg;

	// ==========================================================
	// bus answer phase
	typedef enum logic [1:0] {
		PRG_BUS_IDLE = 2'b01,
		PRG_BUS_ACK = 2'b10
	} prg_bus_t;

	// ==========================================================
	// one settings set, software copy or active copy
	typedef struct packed {
		logic [2:0] input_form_sel;
		logic [1:0] input_invert_sel;
		logic [1:0] clear_mode_sel;
		logic gear_switch_enable;
		logic gear_switch_sequence;
		logic [16:0] gear_num_first;
		logic [16:0] gear_denom;
		logic [16:0] gear_num_second;
	} prg_cfg_t;

	// ==========================================================
	// whole state of the top module
	typedef struct packed {
		prg_bus_t bus;
		logic [31:0] rdata;
		prg_cfg_t cfg;
		prg_cfg_t act;
		logic gear2;
		logic loop_en;
		logic [5:0] prev;
		logic signed [19:0] acc;
		logic signed [31:0] err;
		logic signed [31:0] refc;
	} prg_state_t;

endpackage

// *** prg_pin_sync.sv ***
// three-stage synchroniser with agreement filter for W asynchronous pins
// assumes pins are asynchronous to sys_clk; outputs start low after reset
`timescale 1ns/100ps
module prg_pin_sync #(
	parameter int W = 8
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] flt;
	} prg_sync_t;

	prg_sync_t st_ff;
	prg_sync_t nxt_st;

	// ==========================================================
	// s1 only feeds s2; a change counts once s2 and s3 agree
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = pin_in;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < W; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) begin
				nxt_st.flt[i] = st_ff.s3[i];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pin_out = st_ff.flt;
endmodule

// *** prg_gear_input.sv ***
// pulse reference decoder, electronic gear and position error counter
// assumes pins are asynchronous; servo state and feedback pulses come from sys_clk logic
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "prg_map.svh"
module prg_gear_input (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic count_pulse_in,
	input wire logic direction_in,
	input wire logic forward_pulse_in,
	input wire logic reverse_pulse_in,
	input wire logic phase_a_in,
	input wire logic phase_b_in,
	input wire logic error_clear_n,
	input wire logic gear_select_n,
	input wire logic servo_on,
	input wire logic overtravel,
	input wire logic zero_clamp,
	input wire logic fb_fwd_pulse,
	input wire logic fb_rev_pulse,
	output logic pos_loop_enable,
	output logic signed [31:0] err_count
);
	import prg_pkg::*;

	prg_pkg::prg_state_t st_ff;
	prg_pkg::prg_state_t nxt_st;
	logic [7:0] f;
	logic ref_up;
	logic ref_dn;
	logic clr_now;
	logic restart_now;
	logic p_now;
	logic p_old;
	logic d_now;
	logic a_chg;
	logic b_chg;
	logic q_fwd;
	logic [16:0] num_sel;
	logic signed [19:0] acc_in;

	// ==========================================================
	// gear values outside 1..100000 are pulled to the nearest end
	function automatic logic [16:0] gear_clamp(input logic [31:0] v);
		if (v[16:0] == 17'h0_0000 && v[31:17] == 15'h0000) begin
			return `PRG_GEAR_MIN;
		end else if (v > {15'h0000, `PRG_GEAR_MAX}) begin
			return `PRG_GEAR_MAX;
		end
		return v[16:0];
	endfunction

	// ==========================================================
	// pins pass four flops; 5 ns sampling resolves 1 us pulse widths at 500 kpps
	prg_pin_sync #(
		.W(8)
	) u_sync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pin_in({gear_select_n, error_clear_n, phase_b_in, phase_a_in,
			reverse_pulse_in, forward_pulse_in, direction_in, count_pulse_in}),
		.pin_out(f)
	);

	// ==========================================================
	// edge decode of the active form
	always_comb begin
		p_now = f[0] ^ st_ff.act.input_invert_sel[1];
		p_old = st_ff.prev[0] ^ st_ff.act.input_invert_sel[1];
		d_now = f[1] ^ st_ff.act.input_invert_sel[0];
		a_chg = f[4] ^ st_ff.prev[4];
		b_chg = f[5] ^ st_ff.prev[5];
		q_fwd = st_ff.prev[4] ^ f[5]; // B leading A gives 1
		ref_up = 1'b0;
		ref_dn = 1'b0;
		unique case (st_ff.act.input_form_sel)
			`PRG_FORM_PD: begin
				ref_up = p_now & ~p_old & d_now;
				ref_dn = p_now & ~p_old & ~d_now;
			end
			`PRG_FORM_FR: begin
				// simultaneous edges on both lines cancel
				ref_up = f[2] & ~st_ff.prev[2] & ~(f[3] & ~st_ff.prev[3]);
				ref_dn = f[3] & ~st_ff.prev[3] & ~(f[2] & ~st_ff.prev[2]);
			end
			`PRG_FORM_Q1: begin
				ref_up = f[4] & ~st_ff.prev[4] & ~b_chg & q_fwd;
				ref_dn = f[4] & ~st_ff.prev[4] & ~b_chg & ~q_fwd;
			end
			`PRG_FORM_Q2: begin
				ref_up = a_chg & ~b_chg & q_fwd;
				ref_dn = a_chg & ~b_chg & ~q_fwd;
			end
			`PRG_FORM_Q4: begin
				// both phases moving at once is illegal and is dropped
				ref_up = (a_chg ^ b_chg) & q_fwd;
				ref_dn = (a_chg ^ b_chg) & ~q_fwd;
			end
			default: begin
				ref_up = 1'b0;
				ref_dn = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// clear sources and restart strobe
	always_comb begin
		clr_now = ~f[6];
		unique case (st_ff.act.clear_mode_sel)
			`PRG_CLR_OFF: clr_now = clr_now | ~servo_on;
			`PRG_CLR_ALL: clr_now = clr_now | ~servo_on | (overtravel & ~zero_clamp);
			default: clr_now = clr_now; // mode 1 keeps pulses
		endcase
		restart_now = (st_ff.bus == PRG_BUS_ACK) & avs_write & (avs_address == `PRG_OFF_CTRL)
			& avs_writedata[`PRG_RESTART_BIT];
		num_sel = st_ff.gear2 ? st_ff.act.gear_num_second : st_ff.act.gear_num_first;
		acc_in = st_ff.acc;
		if (ref_up) begin
			acc_in = st_ff.acc + signed'({3'h0, num_sel});
		end else if (ref_dn) begin
			acc_in = st_ff.acc - signed'({3'h0, num_sel});
		end
	end

	// ==========================================================
	// next state: bus, settings, gear accumulator, counters
	always_comb begin
		nxt_st = st_ff;
		nxt_st.prev = f[5:0];
		// bus: one wait cycle, read data loaded while waitrequest is high
		unique case (st_ff.bus)
			PRG_BUS_IDLE: begin
				if (avs_read | avs_write) begin
					nxt_st.bus = PRG_BUS_ACK;
				end
				nxt_st.rdata = 32'h0000_0000;
				unique case (avs_address)
					`PRG_OFF_CTRL: begin
						nxt_st.rdata[`PRG_FORM_LSB +: 3] = st_ff.cfg.input_form_sel;
						nxt_st.rdata[`PRG_INV_LSB +: 2] = st_ff.cfg.input_invert_sel;
						nxt_st.rdata[`PRG_CLR_LSB +: 2] = st_ff.cfg.clear_mode_sel;
						nxt_st.rdata[`PRG_GSW_EN_BIT] = st_ff.cfg.gear_switch_enable;
						nxt_st.rdata[`PRG_GSW_SEQ_BIT] = st_ff.cfg.gear_switch_sequence;
					end
					`PRG_OFF_NUM1: nxt_st.rdata = {15'h0000, st_ff.cfg.gear_num_first};
					`PRG_OFF_DENOM: nxt_st.rdata = {15'h0000, st_ff.cfg.gear_denom};
					`PRG_OFF_NUM2: nxt_st.rdata = {15'h0000, st_ff.cfg.gear_num_second};
					`PRG_OFF_ERR: nxt_st.rdata = st_ff.err;
					`PRG_OFF_REF: nxt_st.rdata = st_ff.refc;
					`PRG_OFF_STAT: nxt_st.rdata = {26'h000_0000, st_ff.act.input_form_sel,
						st_ff.gear2, st_ff.loop_en, f[6]};
					default: nxt_st.rdata = 32'h0000_0000;
				endcase
			end
			PRG_BUS_ACK: begin
				nxt_st.bus = PRG_BUS_IDLE;
				if (avs_write) begin
					unique case (avs_address)
						`PRG_OFF_CTRL: begin
							nxt_st.cfg.input_form_sel = avs_writedata[`PRG_FORM_LSB +: 3];
							nxt_st.cfg.input_invert_sel = avs_writedata[`PRG_INV_LSB +: 2];
							nxt_st.cfg.clear_mode_sel = avs_writedata[`PRG_CLR_LSB +: 2];
							nxt_st.cfg.gear_switch_enable = avs_writedata[`PRG_GSW_EN_BIT];
							nxt_st.cfg.gear_switch_sequence = avs_writedata[`PRG_GSW_SEQ_BIT];
						end
						`PRG_OFF_NUM1: nxt_st.cfg.gear_num_first = gear_clamp(avs_writedata);
						`PRG_OFF_DENOM: nxt_st.cfg.gear_denom = gear_clamp(avs_writedata);
						`PRG_OFF_NUM2: nxt_st.cfg.gear_num_second = gear_clamp(avs_writedata);
						default: nxt_st.cfg = st_ff.cfg; // read-only or unmapped: ignored
					endcase
				end
			end
			default: nxt_st.bus = PRG_BUS_IDLE;
		endcase
		// gear select: sequence 0 follows at once, 1 waits for an idle accumulator
		if (!st_ff.act.gear_switch_sequence || (st_ff.acc == 20'sh0_0000 && !ref_up && !ref_dn)) begin
			nxt_st.gear2 = st_ff.act.gear_switch_enable & ~f[7];
		end
		// drain one gear unit per cycle; nothing caps num/denom, so ratios above 400 fall behind 500 kpps
		nxt_st.acc = acc_in;
		nxt_st.err = st_ff.err;
		if (acc_in >= signed'({3'h0, st_ff.act.gear_denom})) begin
			nxt_st.acc = acc_in - signed'({3'h0, st_ff.act.gear_denom});
			nxt_st.err = st_ff.err + 32'sh0000_0001;
		end else if (acc_in <= -signed'({3'h0, st_ff.act.gear_denom})) begin
			nxt_st.acc = acc_in + signed'({3'h0, st_ff.act.gear_denom});
			nxt_st.err = st_ff.err - 32'sh0000_0001;
		end
		if (fb_fwd_pulse & ~fb_rev_pulse) begin
			nxt_st.err = nxt_st.err - 32'sh0000_0001;
		end else if (fb_rev_pulse & ~fb_fwd_pulse) begin
			nxt_st.err = nxt_st.err + 32'sh0000_0001;
		end
		if (ref_up) begin
			nxt_st.refc = st_ff.refc + 32'sh0000_0001;
		end else if (ref_dn) begin
			nxt_st.refc = st_ff.refc - 32'sh0000_0001;
		end
		// clearing wipes both the counter and the gear remainder
		if (clr_now) begin
			nxt_st.err = 32'sh0000_0000;
			nxt_st.acc = 20'sh0_0000;
		end
		nxt_st.loop_en = f[6] & servo_on;
		// settings move to the active set only on restart
		if (restart_now) begin
			nxt_st.act = nxt_st.cfg;
			nxt_st.acc = 20'sh0_0000;
			nxt_st.err = 32'sh0000_0000;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
			st_ff.bus <= PRG_BUS_IDLE;
			st_ff.cfg.gear_num_first <= `PRG_GEAR_RST;
			st_ff.cfg.gear_denom <= `PRG_GEAR_RST;
			st_ff.cfg.gear_num_second <= `PRG_GEAR_RST;
			st_ff.act.gear_num_first <= `PRG_GEAR_RST;
			st_ff.act.gear_denom <= `PRG_GEAR_RST;
			st_ff.act.gear_num_second <= `PRG_GEAR_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & (st_ff.bus != PRG_BUS_ACK);
	assign avs_readdata = st_ff.rdata;
	assign pos_loop_enable = st_ff.loop_en;
	assign err_count = st_ff.err;

	// ==========================================================
	// checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	clear_zero_a: assert property (!f[6] |=> err_count == 32'sh0000_0000)
		else $error("error counter not zero under clear");
	loop_off_a: assert property (!f[6] |=> !pos_loop_enable)
		else $error("position loop enabled under clear");
	pd_dir_a: assert property (ref_up && !ref_dn && st_ff.act.input_form_sel == `PRG_FORM_PD
		|=> st_ff.refc == $past(st_ff.refc) + 32'sh0000_0001 && $past(d_now))
		else $error("forward pulse without high direction");
	fr_rev_a: assert property (st_ff.act.input_form_sel == `PRG_FORM_FR && f[3] && !st_ff.prev[3]
		&& !(f[2] && !st_ff.prev[2]) |=> st_ff.refc == $past(st_ff.refc) - 32'sh0000_0001)
		else $error("reverse line did not decrement");
	quad_fwd_a: assert property (st_ff.act.input_form_sel == `PRG_FORM_Q4 && st_ff.prev[5:4] == 2'h0
		&& f[5:4] == 2'h2 |-> ref_up && !ref_dn)
		else $error("B leading A not forward");
	keep_err_a: assert property (st_ff.act.clear_mode_sel == `PRG_CLR_NEVER && f[6] && !restart_now
		&& !fb_fwd_pulse && !fb_rev_pulse && st_ff.acc == 20'sh0_0000 && !ref_up && !ref_dn
		|=> $stable(err_count))
		else $error("error counter lost pulses");
	soff_clr_a: assert property (st_ff.act.clear_mode_sel == `PRG_CLR_OFF && !servo_on
		|=> err_count == 32'sh0000_0000)
		else $error("servo-off did not clear");
	gear_step_a: assert property (!clr_now && !restart_now && !fb_fwd_pulse && !fb_rev_pulse
		&& acc_in >= signed'({3'h0, st_ff.act.gear_denom}) |=> err_count == $past(err_count) + 32'sh0000_0001)
		else $error("gear unit not counted");
	gear_range_a: assert property (st_ff.act.gear_num_first >= `PRG_GEAR_MIN
		&& st_ff.act.gear_denom <= `PRG_GEAR_MAX && st_ff.act.gear_denom >= `PRG_GEAR_MIN)
		else $error("gear value out of range");
	act_hold_a: assert property (!restart_now |=> $stable(st_ff.act))
		else $error("settings changed without restart");

	// ==========================================================
	// reverse direction, unused forms, gear select and the remaining clear sources
	pd_rev_a: assert property (ref_dn && !ref_up && st_ff.act.input_form_sel == `PRG_FORM_PD
		|=> st_ff.refc == $past(st_ff.refc) - 32'sh0000_0001 && !$past(d_now))
		else $error("reverse pulse without low direction");
	form_none_a: assert property (st_ff.act.input_form_sel > `PRG_FORM_Q4 |-> !ref_up && !ref_dn)
		else $error("unused input form counted a pulse");
	// sequence 0 follows the synced select pin with one cycle of latency
	gear_sel_a: assert property (st_ff.act.gear_switch_enable && !st_ff.act.gear_switch_sequence
		|=> st_ff.gear2 == !$past(f[7]))
		else $error("gear select not followed");
	// sequence 1 must not swap numerators under a half-spent remainder
	gear_seq_a: assert property (st_ff.act.gear_switch_sequence && st_ff.acc != 20'sh0_0000
		|=> $stable(st_ff.gear2))
		else $error("gear swapped with remainder pending");
	// in mode 2 an overtravel without zero clamp clears the counter
	ot_clear_a: assert property (st_ff.act.clear_mode_sel == `PRG_CLR_ALL && overtravel
		&& !zero_clamp |=> err_count == 32'sh0000_0000)
		else $error("overtravel did not clear");
	loop_on_a: assert property (f[6] && servo_on |=> pos_loop_enable)
		else $error("position loop held off without clear");

	// ==========================================================
	// covers of the main scenarios
	pd_fwd_c: cover property (st_ff.act.input_form_sel == `PRG_FORM_PD && ref_up);
	ot_clear_c: cover property (st_ff.act.clear_mode_sel == `PRG_CLR_ALL && overtravel && !zero_clamp);
	quad4_c: cover property (st_ff.act.input_form_sel == `PRG_FORM_Q4 && ref_dn);
	gear2_c: cover property (st_ff.gear2 && ref_up);
	clear_c: cover property (!f[6] && err_count != 32'sh0000_0000);
endmodule

// *** prg_host_model.sv ***
// host motion controller model: drives the pulse train pins of the gear input
// assumes the caller blocks on send; pins idle low like a line driver at rest
`timescale 1ns/100ps
module prg_host_model #(
	parameter int HALF = 200,
	parameter int QTR = 250
) (
	input wire logic sys_clk,
	output logic count_pulse_in,
	output logic direction_in,
	output logic forward_pulse_in,
	output logic reverse_pulse_in,
	output logic phase_a_in,
	output logic phase_b_in
);
	// ==========================================================
	// idle levels
	initial begin
		{count_pulse_in, direction_in, forward_pulse_in, reverse_pulse_in, phase_a_in, phase_b_in} = 6'h00;
	end

	task automatic hold(input int c);
		repeat (c) @(posedge sys_clk);
	endtask

	// ==========================================================
	// pulse trains; 1 us widths and 1.25 us quadrature steps keep every form inside its rate limit
	task automatic send(input logic [2:0] form, input int n, input logic fwd);
		logic [7:0] seq;
		int k;
		seq = fwd ? 8'b0111_1000 : 8'b1011_0100;
		hold(1);
		direction_in <= fwd;
		repeat (n) begin
			if (form == 3'h0) begin
				hold(HALF);
				count_pulse_in <= 1'b1;
				hold(HALF);
				count_pulse_in <= 1'b0;
			end else if (form == 3'h1) begin
				hold(HALF);
				forward_pulse_in <= fwd;
				reverse_pulse_in <= !fwd;
				hold(HALF);
				forward_pulse_in <= 1'b0;
				reverse_pulse_in <= 1'b0;
			end else begin
				// 1000 cycles a cycle is 200 kpps, legal at every multiplier
				for (k = 0; k < 4; k++) begin
					hold(QTR);
					{phase_a_in, phase_b_in} <= seq[7-2*k -: 2];
				end
			end
		end
		hold(HALF);
	endtask
endmodule

// *** test_pulse_reference_gear_input.sv ***
// self-checking bench for the pulse reference gear input
// assumes prg_host_model drives the pulse pins; the bench drives bus and servo levels
`timescale 1ns/100ps
`include "prg_map.svh"
module test_pulse_reference_gear_input;
	import prg_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0000_0000;
	logic [31:0] avs_readdata, rv, r0;
	logic avs_waitrequest, pos_loop_enable;
	logic count_pulse_in, direction_in, forward_pulse_in, reverse_pulse_in, phase_a_in, phase_b_in;
	logic error_clear_n = 1'b1;
	logic gear_select_n = 1'b1;
	logic servo_on = 1'b1;
	logic overtravel = 1'b0;
	logic zero_clamp = 1'b0;
	logic fb_fwd_pulse = 1'b0;
	logic fb_rev_pulse = 1'b0;
	logic signed [31:0] err_count;
	logic [5:0] tab [6] = '{6'h01, 6'h0C, 6'h10, 6'h2D, 6'h2E, 6'h21};
	logic [5:0] c;
	int n_fail = 0;
	int checked = 0;
	int cyc = 0;
	int k;

	prg_gear_input uut (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .count_pulse_in(count_pulse_in), .direction_in(direction_in),
		.forward_pulse_in(forward_pulse_in), .reverse_pulse_in(reverse_pulse_in), .phase_a_in(phase_a_in),
		.phase_b_in(phase_b_in), .error_clear_n(error_clear_n), .gear_select_n(gear_select_n),
		.servo_on(servo_on), .overtravel(overtravel), .zero_clamp(zero_clamp), .fb_fwd_pulse(fb_fwd_pulse),
		.fb_rev_pulse(fb_rev_pulse), .pos_loop_enable(pos_loop_enable), .err_count(err_count));
	prg_host_model host (.sys_clk(sys_clk), .count_pulse_in(count_pulse_in), .direction_in(direction_in),
		.forward_pulse_in(forward_pulse_in), .reverse_pulse_in(reverse_pulse_in), .phase_a_in(phase_a_in),
		.phase_b_in(phase_b_in));

	// ==========================================================
	// clock and hang guard
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_fail++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
		checked++;
		if (got !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, e, got);
		end
	endtask

	// ==========================================================
	// bus access; the request stands until waitrequest is sampled low at a rising edge
	// no cycle count is assumed: only the hang guard ends a stuck wait
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		@(posedge sys_clk);
		while (avs_waitrequest) @(posedge sys_clk);
		rv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rchk(input logic [4:0] a, input logic [31:0] e, input string what);
		bus(1'b0, a, 32'h0000_0000);
		chk(what, e, rv);
	endtask

	task automatic restart(input logic [2:0] f, input logic [1:0] inv, input logic [1:0] clr, input logic en,
		input logic sq);
		bus(1'b1, `PRG_OFF_CTRL, {1'b1, 17'h0_0000, sq, en, 2'h0, clr, 2'h0, inv, 1'b0, f});
	endtask

	// host pulses, then enough cycles for sync, decode and gear stepping
	task automatic pulses(input logic [2:0] f, input int n, input logic fwd);
		host.send(f, n, fwd);
		repeat (40) @(posedge sys_clk);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		rchk(`PRG_OFF_CTRL, 32'h0000_0000, "ctrl reset");
		for (k = 0; k < 3; k++) begin
			rchk(5'(4 * k + 4), 32'h0000_0001, "gear reset");
		end
		bus(1'b1, `PRG_OFF_NUM1, 32'h0000_0000);
		rchk(`PRG_OFF_NUM1, 32'h0000_0001, "num zero");
		bus(1'b1, `PRG_OFF_NUM1, 32'h0003_0D40);
		rchk(`PRG_OFF_NUM1, 32'h0001_86A0, "num max");
		bus(1'b1, 5'h1C, 32'h0000_0005);
		rchk(5'h1C, 32'h0000_0000, "unmapped");
		bus(1'b1, `PRG_OFF_NUM1, 32'h0000_0001);
		$display("test registers done");
		// inversion codes on pulse-direction form
		for (k = 0; k < 4; k++) begin
			restart(3'h0, 2'(k), 2'h0, 1'b0, 1'b0);
			bus(1'b0, `PRG_OFF_REF, 32'h0000_0000);
			r0 = rv;
			pulses(3'h0, 3, 1'b1);
			rchk(`PRG_OFF_REF, r0 + ((k % 2 == 1) ? 32'hFFFF_FFFD : 32'h0000_0003), "ref inv");
		end
		restart(3'h0, 2'h0, 2'h0, 1'b0, 1'b0);
		pulses(3'h0, 5, 1'b1);
		pulses(3'h0, 2, 1'b0);
		chk("dir err", 32'h0000_0003, err_count);
		fb_fwd_pulse <= 1'b1;
		@(posedge sys_clk);
		fb_fwd_pulse <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("feedback", 32'h0000_0002, err_count);
		fb_rev_pulse <= 1'b1;
		@(posedge sys_clk);
		fb_rev_pulse <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("feedback rev", 32'h0000_0003, err_count);
		$display("test direction done");
		restart(3'h1, 2'h0, 2'h0, 1'b0, 1'b0);
		pulses(3'h1, 4, 1'b1);
		pulses(3'h1, 1, 1'b0);
		chk("sep err", 32'h0000_0003, err_count);
		bus(1'b0, `PRG_OFF_STAT, 32'h0000_0000);
		chk("stat form", 32'h0000_0001, {29'h0, rv[5:3]});
		// quadrature x1, x2, x4: three cycles ahead, one back
		for (k = 0; k < 3; k++) begin
			restart(3'(k + 2), 2'h0, 2'h0, 1'b0, 1'b0);
			pulses(3'(k + 2), 3, 1'b1);
			pulses(3'(k + 2), 1, 1'b0);
			chk("quad err", 32'(2 << k), err_count);
		end
		// unused form codes must count nothing
		restart(3'h5, 2'h0, 2'h0, 1'b0, 1'b0);
		pulses(3'h5, 1, 1'b1);
		chk("form none", 32'h0000_0000, err_count);
		$display("test forms done");
		// ratio 3/2 stays within 0.01..100
		bus(1'b1, `PRG_OFF_NUM1, 32'h0000_0003);
		bus(1'b1, `PRG_OFF_DENOM, 32'h0000_0002);
		restart(3'h0, 2'h0, 2'h0, 1'b0, 1'b0);
		pulses(3'h0, 4, 1'b1);
		chk("gear err", 32'h0000_0006, err_count);
		bus(1'b1, `PRG_OFF_NUM1, 32'h0000_0007);
		bus(1'b1, `PRG_OFF_DENOM, 32'h0000_0001);
		pulses(3'h0, 2, 1'b1);
		chk("pending gear", 32'h0000_0009, err_count);
		restart(3'h0, 2'h0, 2'h0, 1'b0, 1'b0);
		pulses(3'h0, 1, 1'b1);
		chk("new gear", 32'h0000_0007, err_count);
		bus(1'b1, `PRG_OFF_NUM2, 32'h0000_0005);
		gear_select_n <= 1'b0;
		pulses(3'h0, 1, 1'b1);
		chk("switch off", 32'h0000_000E, err_count);
		for (k = 0; k < 2; k++) begin
			restart(3'h0, 2'h0, 2'h0, 1'b1, k[0]);
			pulses(3'h0, 2, 1'b1);
			chk("second gear", 32'h0000_000A, err_count);
			rchk(`PRG_OFF_STAT, 32'h0000_0007, "stat gear");
			gear_select_n <= 1'b1;
			pulses(3'h0, 1, 1'b1);
			chk("first gear", 32'h0000_0011, err_count);
			gear_select_n <= 1'b0;
		end
		gear_select_n <= 1'b1;
		bus(1'b1, `PRG_OFF_NUM1, 32'h0000_0001);
		$display("test gear done");
		restart(3'h0, 2'h0, 2'h0, 1'b0, 1'b0);
		pulses(3'h0, 3, 1'b1);
		error_clear_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		chk("clear err", 32'h0000_0000, err_count);
		chk("clear loop", 32'h0000_0000, {31'h0, pos_loop_enable});
		pulses(3'h0, 2, 1'b1);
		error_clear_n <= 1'b1;
		repeat (10) @(posedge sys_clk);
		chk("after clear", 32'h0000_0000, err_count);
		chk("loop back", 32'h0000_0001, {31'h0, pos_loop_enable});
		// table rows: mode, servo on, overtravel, zero clamp, cleared
		for (k = 0; k < 6; k++) begin
			c = tab[k];
			restart(3'h0, 2'h0, c[5:4], 1'b0, 1'b0);
			pulses(3'h0, 2, 1'b1);
			servo_on <= c[3];
			overtravel <= c[2];
			zero_clamp <= c[1];
			repeat (10) @(posedge sys_clk);
			chk("auto clear", c[0] ? 32'h0000_0000 : 32'h0000_0002, err_count);
			servo_on <= 1'b1;
			overtravel <= 1'b0;
			zero_clamp <= 1'b0;
		end
		$display("test clear done");
		end_of_test();
	end
endmodule
